// ===== nand_host_ctrl.sv
// host controller: status, enhanced status, set feature, reset, parameter page
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_regs.svh"
module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter logic WIDE_PART = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output pins_s pinOut,
  input wire logic [7:0] ioIn,
  input wire logic rbN
);

  localparam int WHR_CYC = (`T_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ADL_CYC = (`T_ADL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WB_CYC = (`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RR_CYC = (`T_RR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  state_e state_r;
  state_e ret_r;
  op_e op_r;
  logic [9:0] idx_r;
  logic [9:0] len_r;
  logic [3:0] gap_r;
  logic chkReset_r;
  logic busy_r;
  logic refused_r;
  logic otp_r;
  logic wpRel_r;
  logic [23:0] row_r;
  logic [1:0] drive_r;
  logic [7:0] statusVal_r;
  logic resetOk_r;
  logic statMode_r;
  logic fieldsOk_r;
  logic copyOk_r;
  logic crcOk_r;
  logic [15:0] crcRx_r;
  logic [31:0] rdata_r;
  pins_s pins_r;
  logic [7:0] ppMem [256];

  logic ctrlWr;
  logic startOk;
  op_e startOp;
  logic lastIdx;
  logic rdCap;
  logic ppCopy0;
  logic [7:0] ppByte;
  logic crcInit;
  logic crcEn;
  logic [15:0] crcCalc;

  assign ctrlWr = regWr && (regAddr == `REG_CTRL);
  assign startOp = op_e'(regWdata[2:0]);
  // enhanced status is withheld while otp mode is on, including an otp bit written
  // in the same word as the start; reset only starts from idle
  assign startOk = (state_r == ST_IDLE) && (startOp != OP_NONE) && (regWdata[2:0] <= 3'h5)
                   && !(startOp == OP_ESTATUS
                        && (otp_r || regWdata[`CTRL_OTP]));
  assign lastIdx = (idx_r == len_r - 10'd1);
  assign rdCap = (state_r == ST_RDH);
  assign ppCopy0 = (idx_r[9:8] == 2'h0);
  assign ppByte = idx_r[7:0];
  assign crcInit = (state_r == ST_CMD) && (op_r == OP_PARAM);
  assign crcEn = rdCap && (op_r == OP_PARAM) && ppCopy0 && (ppByte < `PP_CRC_LO);

  nand_crc16 #(
    .POLY(`CRC_POLY),
    .SEED(`CRC_SEED)
  ) crcUnit (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .init(crcInit),
    .en(crcEn),
    .data(ioIn),
    .crc(crcCalc)
  );

  // expected contents of the first copy; bytes not listed are not checked
  function automatic logic byteOk(input logic [7:0] i, input logic [7:0] d);
    case (i)
      8'd0: byteOk = (d == 8'h4f);
      8'd1: byteOk = (d == 8'h4e);
      8'd2: byteOk = (d == 8'h46);
      8'd3: byteOk = (d == 8'h49);
      8'd6: byteOk = (d == (WIDE_PART ? `EXP_FEAT_X16 : `EXP_FEAT_X8));
      8'd8: byteOk = (d == `EXP_OPTCMD);
      8'd81: byteOk = (d == 8'h08);
      8'd84: byteOk = (d == 8'h40);
      8'd87: byteOk = (d == 8'h02);
      8'd90: byteOk = (d == 8'h10);
      8'd92: byteOk = (d == 8'h40);
      8'd97: byteOk = (d == 8'h08);
      8'd100: byteOk = (d == 8'h01);
      8'd101: byteOk = (d == `EXP_ADDRCYC);
      8'd110: byteOk = (d == `EXP_NOP);
      8'd112: byteOk = (d == `EXP_ECC);
      8'd129, 8'd131: byteOk = (d == `EXP_TM33) || (d == `EXP_TM18);
      8'd133: byteOk = (d == 8'h58);
      8'd134: byteOk = (d == 8'h02);
      8'd135: byteOk = (d == 8'h88);
      8'd136: byteOk = (d == 8'h13);
      8'd137: byteOk = (d == 8'h19);
      8'd139: byteOk = (d == 8'h3c);
      8'd80, 8'd82, 8'd83, 8'd85, 8'd138, 8'd140: byteOk = (d == 8'h00);
      default: byteOk = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] outByte(input state_e s, input op_e o,
                                         input logic [9:0] i, input logic [23:0] row,
                                         input logic [1:0] drv);
    outByte = 8'h00;
    if (s == ST_CMD || s == ST_CMDH) begin
      case (o)
        OP_STATUS: outByte = `CMD_STATUS;
        OP_ESTATUS: outByte = `CMD_ESTATUS;
        OP_SETFEAT: outByte = `CMD_SETFEAT;
        OP_PARAM: outByte = `CMD_PARAM;
        OP_RESET: outByte = `CMD_RESET;
        default: outByte = 8'h00;
      endcase
    end else if (s == ST_ADR || s == ST_ADRH) begin
      case (o)
        OP_ESTATUS: outByte = row[8*i[1:0] +: 8];
        OP_SETFEAT: outByte = `FEAT_DRIVE;
        default: outByte = `PARAM_ADDR;
      endcase
    end else if (s == ST_DAT || s == ST_DATH) begin
      outByte = (i == 10'd0) ? {6'h00, drv} : 8'h00;
    end
  endfunction

  // sequencer; pins follow the state one clock later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ret_r <= ST_IDLE;
      op_r <= OP_NONE;
      idx_r <= 10'd0;
      len_r <= 10'd1;
      gap_r <= 4'h1;
      chkReset_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (ctrlWr && startOk) begin
            op_r <= startOp;
            chkReset_r <= 1'b0;
            state_r <= ST_CMD;
          end
        end
        ST_CMD: state_r <= ST_CMDH;
        ST_CMDH: begin
          idx_r <= 10'd0;
          case (op_r)
            OP_STATUS: begin
              len_r <= 10'd1;
              gap_r <= 4'(WHR_CYC);
              ret_r <= ST_RD;
              state_r <= ST_GAP;
            end
            OP_ESTATUS: begin
              len_r <= 10'd3;
              state_r <= ST_ADR;
            end
            OP_RESET: begin
              gap_r <= 4'(WB_CYC);
              ret_r <= ST_WAIT;
              state_r <= ST_GAP;
            end
            default: begin
              len_r <= 10'd1;
              state_r <= ST_ADR;
            end
          endcase
        end
        ST_ADR: state_r <= ST_ADRH;
        ST_ADRH: begin
          if (!lastIdx) begin
            idx_r <= idx_r + 10'd1;
            state_r <= ST_ADR;
          end else begin
            idx_r <= 10'd0;
            state_r <= ST_GAP;
            if (op_r == OP_ESTATUS) begin
              len_r <= 10'd1;
              gap_r <= 4'(WHR_CYC);
              ret_r <= ST_RD;
            end else if (op_r == OP_SETFEAT) begin
              len_r <= 10'd4;
              gap_r <= 4'(ADL_CYC);
              ret_r <= ST_DAT;
            end else begin
              gap_r <= 4'(WB_CYC);
              ret_r <= ST_WAIT;
            end
          end
        end
        ST_DAT: state_r <= ST_DATH;
        ST_DATH: begin
          if (!lastIdx) begin
            idx_r <= idx_r + 10'd1;
            state_r <= ST_DAT;
          end else begin
            gap_r <= 4'(WB_CYC);
            ret_r <= ST_WAIT;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_r <= 4'h1) begin
            state_r <= ret_r;
          end else begin
            gap_r <= gap_r - 4'h1;
          end
        end
        ST_WAIT: begin
          if (rbN) begin
            if (op_r == OP_RESET) begin
              op_r <= OP_STATUS;
              chkReset_r <= 1'b1;
              state_r <= ST_CMD;
            end else if (op_r == OP_PARAM) begin
              idx_r <= 10'd0;
              len_r <= `PP_TOTAL;
              gap_r <= 4'(RR_CYC);
              ret_r <= ST_RD;
              state_r <= ST_GAP;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_RD: state_r <= ST_RDH;
        ST_RDH: begin
          if (!lastIdx) begin
            // one high cycle between bytes, else the device never advances
            idx_r <= idx_r + 10'd1;
            gap_r <= 4'h1;
            ret_r <= ST_RD;
            state_r <= ST_GAP;
          end else begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_r <= '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1, reN: 1'b1,
                  wpN: 1'b0, ioOe: 1'b0, ioOut: 8'h00};
    end else begin
      pins_r.ceN <= (state_r == ST_IDLE) || (state_r == ST_DONE);
      pins_r.cle <= (state_r == ST_CMD) || (state_r == ST_CMDH);
      pins_r.ale <= (state_r == ST_ADR) || (state_r == ST_ADRH);
      pins_r.weN <= !((state_r == ST_CMD) || (state_r == ST_ADR) || (state_r == ST_DAT));
      pins_r.reN <= (state_r != ST_RD) && (state_r != ST_RDH);
      pins_r.wpN <= wpRel_r;
      pins_r.ioOe <= (state_r == ST_CMD) || (state_r == ST_CMDH) || (state_r == ST_ADR)
                     || (state_r == ST_ADRH) || (state_r == ST_DAT) || (state_r == ST_DATH);
      pins_r.ioOut <= outByte(state_r, op_r, idx_r, row_r, drive_r);
    end
  end

  // software-side control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_r <= 1'b0;
      wpRel_r <= 1'b0;
      row_r <= 24'h000000;
      drive_r <= `DRIVE_RESET;
      refused_r <= 1'b0;
    end else begin
      if (ctrlWr) begin
        otp_r <= regWdata[`CTRL_OTP];
        wpRel_r <= regWdata[`CTRL_WPREL];
        refused_r <= !startOk && (regWdata[2:0] != 3'h0);
      end
      if (regWr && regAddr == `REG_ROW) begin
        row_r <= regWdata[23:0];
      end
      // shadow only changes by software; a reset op leaves it alone
      if (regWr && regAddr == `REG_DRIVE && state_r == ST_IDLE) begin
        drive_r <= regWdata[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= !((state_r == ST_DONE) || (state_r == ST_IDLE && !(ctrlWr && startOk)));
    end
  end

  // status capture and device mode tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusVal_r <= 8'h00;
      resetOk_r <= 1'b0;
      statMode_r <= 1'b0;
    end else begin
      if (state_r == ST_CMDH) begin
        // any fresh command other than 70h or 78h ends status output mode
        statMode_r <= (op_r == OP_STATUS) || (op_r == OP_ESTATUS);
      end
      if (rdCap && (op_r == OP_STATUS || op_r == OP_ESTATUS)) begin
        statusVal_r <= ioIn;
        if (chkReset_r) begin
          resetOk_r <= (ioIn == `RESET_STATUS);
        end
      end
    end
  end

  // parameter page capture and checks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fieldsOk_r <= 1'b0;
      copyOk_r <= 1'b0;
      crcOk_r <= 1'b0;
      crcRx_r <= 16'h0000;
    end else begin
      if (crcInit) begin
        fieldsOk_r <= 1'b1;
        copyOk_r <= 1'b1;
        crcOk_r <= 1'b0;
      end else if (rdCap && op_r == OP_PARAM) begin
        if (ppCopy0) begin
          if (!byteOk(ppByte, ioIn)) begin
            fieldsOk_r <= 1'b0;
          end
          if (ppByte == `PP_CRC_LO) begin
            crcRx_r[7:0] <= ioIn;
          end
          if (ppByte == `PP_CRC_HI) begin
            crcRx_r[15:8] <= ioIn;
          end
        end else if (ioIn != ppMem[ppByte]) begin
          copyOk_r <= 1'b0;
        end
      end
      if (state_r == ST_DONE && op_r == OP_PARAM) begin
        crcOk_r <= (crcCalc == crcRx_r);
      end
    end
  end

  // first copy only; later copies are compared, not stored
  always_ff @(posedge core_clk) begin
    if (rdCap && op_r == OP_PARAM && ppCopy0) begin
      ppMem[ppByte] <= ioIn;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (regRd) begin
      if (regAddr == `REG_CTRL) begin
        rdata_r <= {22'h0, wpRel_r, otp_r, 5'h00, op_r};
      end else if (regAddr == `REG_ROW) begin
        rdata_r <= {8'h00, row_r};
      end else if (regAddr == `REG_DRIVE) begin
        rdata_r <= {30'h0, drive_r};
      end else if (regAddr == `REG_STAT) begin
        rdata_r <= {11'h000,
                    !statusVal_r[7],
                    statusVal_r[6],
                    statusVal_r[5],
                    statusVal_r[1],
                    statusVal_r[0] && statusVal_r[5],
                    statusVal_r, 1'b0, statMode_r, resetOk_r, fieldsOk_r,
                    copyOk_r, crcOk_r, refused_r, busy_r};
      end else if (regAddr == `REG_CRC) begin
        rdata_r <= {crcRx_r, crcCalc};
      end else if (regAddr[11:10] == `REG_PPWIN) begin
        rdata_r <= {24'h000000, ppMem[regAddr[9:2]]};
      end else begin
        rdata_r <= 32'h00000000;
      end
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign regRdata = rdata_r;
  assign pinOut = pins_r;

endmodule
`default_nettype wire

// ===== nand_host_regs.svh
// constants for the host-side nand status, parameter page and feature controller
// Overview of operation
// - bytes 254-255 hold CRC over bytes 0-253 with polynomial 8005h.
// - CRC seeds 4F4Eh, no bit reversal, no reflection, no final XOR.
// - after 70h each read cycle returns the status register.
// - device stays in status mode until next command; 00h resumes data reads.
// - enhanced status is 78h plus three row address cycles, returns plane status.
// - host never issues 78h during reset or while OTP mode is enabled.
// - set feature EFh at address 10h loads drive strength in byte 1, rest zero.
// - host never issues reset in the middle of a set-feature sequence.
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

`define CLK_PERIOD_NS 100
`define T_WHR_NS 60
`define T_ADL_NS 300
`define T_WB_NS 100
`define T_RR_NS 20

`define CMD_STATUS 8'h70
`define CMD_ESTATUS 8'h78
`define CMD_SETFEAT 8'hef
`define CMD_PARAM 8'hec
`define CMD_RESET 8'hff
`define FEAT_DRIVE 8'h10
`define PARAM_ADDR 8'h00
`define DRIVE_RESET 2'h0
`define RESET_STATUS 8'he0

`define CRC_POLY 16'h8005
`define CRC_SEED 16'h4f4e
`define PP_TOTAL 10'd768
`define PP_CRC_LO 8'hfe
`define PP_CRC_HI 8'hff

`define REG_CTRL 12'h000
`define REG_ROW 12'h004
`define REG_DRIVE 12'h008
`define REG_STAT 12'h00c
`define REG_CRC 12'h010
`define REG_PPWIN 2'h1
`define CTRL_OTP 8
`define CTRL_WPREL 9

`define EXP_FEAT_X8 8'h10
`define EXP_FEAT_X16 8'h11
`define EXP_OPTCMD 8'h3f
`define EXP_ADDRCYC 8'h23
`define EXP_NOP 8'h04
`define EXP_ECC 8'h04
`define EXP_TM33 8'h3f
`define EXP_TM18 8'h1f

`endif

// ===== nand_host_pkg.sv
// types shared by the host-side nand controller
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_STATUS = 3'h1,
    OP_ESTATUS = 3'h2,
    OP_SETFEAT = 3'h3,
    OP_PARAM = 3'h4,
    OP_RESET = 3'h5
  } op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_CMDH = 4'h3,
    ST_ADR = 4'h2,
    ST_ADRH = 4'h6,
    ST_DAT = 4'h7,
    ST_DATH = 4'h5,
    ST_GAP = 4'h4,
    ST_WAIT = 4'hc,
    ST_RD = 4'hd,
    ST_RDH = 4'hf,
    ST_DONE = 4'he
  } state_e;

  typedef struct packed {
    logic ceN;
    logic cle;
    logic ale;
    logic weN;
    logic reN;
    logic wpN;
    logic ioOe;
    logic [7:0] ioOut;
  } pins_s;

endpackage

// ===== nand_crc16.sv
// byte-serial crc16 checker for the parameter page
`timescale 1ns/10ps
`default_nettype none
module nand_crc16 #(
  parameter logic [15:0] POLY = 16'h8005,
  parameter logic [15:0] SEED = 16'h4f4e
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // msb first, no reflection and no final xor
  always_comb begin
    crc_nxt = crc_r;
    for (int b = 7; b >= 0; b--) begin
      if (crc_nxt[15] ^ data[b]) begin
        crc_nxt = {crc_nxt[14:0], 1'b0} ^ POLY;
      end else begin
        crc_nxt = {crc_nxt[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_r <= 16'h0000;
    end else if (init) begin
      crc_r <= SEED;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule
`default_nettype wire

// ===== nand_host_ctrl_chk.sv
// port assertions for the host nand controller
`timescale 1ns/10ps
`default_nettype none
module nand_host_ctrl_chk
  import nand_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire pins_s pinOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // command bytes are seen in the single write-strobe-low cycle
  wire logic cmdLow = !pinOut.weN && pinOut.cle;
  wire logic cmd70 = cmdLow && pinOut.ioOut == 8'h70;
  wire logic cmd78 = cmdLow && pinOut.ioOut == 8'h78;
  wire logic cmdEf = cmdLow && pinOut.ioOut == 8'hef;
  wire logic cmdEc = cmdLow && pinOut.ioOut == 8'hec;
  AST_RDATA_ZERO: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_WE_ONE: assert property ($fell(pinOut.weN) |=> pinOut.weN && $stable(pinOut.ioOut))
    else $error("write strobe not one cycle or byte moved");
  AST_RE_TWO: assert property ($fell(pinOut.reN) |=> !pinOut.reN ##1 pinOut.reN)
    else $error("read strobe not two cycles");
  AST_LATCH_EXCL: assert property (!(pinOut.cle && pinOut.ale))
    else $error("command and address latch together");
  AST_WE_DRIVE: assert property (!pinOut.weN |-> pinOut.ioOe && !pinOut.ceN)
    else $error("write strobe without driven bus");
  AST_RE_FLOAT: assert property (!pinOut.reN |-> !pinOut.ioOe && !pinOut.ceN)
    else $error("host drives bus during read");
  AST_CE_IDLE: assert property (pinOut.ceN |-> pinOut.weN && pinOut.reN && !pinOut.ioOe)
    else $error("strobe active while deselected");
  AST_STAT_READ: assert property (cmd70 |-> ##[2:4] !pinOut.reN)
    else $error("no status read after 70h");
  AST_ESTAT_ROW: assert property (cmd78 |-> ##[1:3] pinOut.ale)
    else $error("no row cycle after 78h");
  AST_FEAT_ADDR: assert property (cmdEf |-> ##[1:3] (pinOut.ale && pinOut.ioOut == 8'h10))
    else $error("set feature without address 10h");
  cover property (cmd70);
  cover property (cmd78);
  cover property (cmdEf);
  cover property (cmdEc);
endmodule
bind nand_host_ctrl nand_host_ctrl_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut));
`default_nettype wire

// ===== nand_dev_model.sv
// behavioural nand device answering the host controller
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model
  import nand_host_pkg::*;
(
  input wire logic core_clk,
  input wire pins_s pinIn,
  output logic [7:0] ioIn,
  output logic rbN,
  output logic [7:0] drive,
  output logic [7:0] rsvOr,
  output logic [23:0] row,
  output logic [15:0] crcVal
);
  logic [7:0] pg [0:255];
  logic [7:0] cmd, fa, st, ob, busy;
  logic [9:0] ptr;
  logic [2:0] cnt;
  logic sMode, weP, reP;
  function automatic logic [15:0] crc16(input int n);
    logic [15:0] c;
    c = 16'h4f4e;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ pg[i][b]) ? 16'h8005 : 16'h0);
    return c;
  endfunction
  initial begin
    foreach (pg[i]) pg[i] = 8'h0;
    {pg[0], pg[1], pg[2], pg[3]} = 32'h4f4e4649;
    pg[4] = 8'h02;
    pg[6] = 8'h10;
    pg[8] = 8'h3f;
    pg[81] = 8'h08;
    pg[84] = 8'h40;
    pg[87] = 8'h02;
    pg[90] = 8'h10;
    pg[92] = 8'h40;
    pg[97] = 8'h08;
    pg[100] = 8'h01;
    pg[101] = 8'h23;
    pg[110] = 8'h04;
    pg[112] = 8'h04;
    pg[129] = 8'h3f;
    pg[131] = 8'h3f;
    {pg[133], pg[134], pg[135], pg[136]} = 32'h58028813;
    {pg[137], pg[138], pg[139], pg[140]} = 32'h19003c00;
    crcVal = crc16(254);
    pg[254] = crcVal[7:0];
    pg[255] = crcVal[15:8];
    {drive, rsvOr, row, cmd, fa, busy, ptr, cnt} = '0;
    {sMode, weP, reP} = 3'b011;
  end
  assign rbN = busy == 8'h0;
  assign st = {pinIn.wpN, rbN, rbN, 5'h0};
  // copies repeat by wrapping the low pointer byte
  assign ob = sMode ? st : pg[ptr[7:0]];
  // released bus shows the inverse so stale data never matches
  assign ioIn = (!pinIn.ceN && !pinIn.reN) ? ob : ~ob;
  always @(posedge core_clk) begin
    weP <= pinIn.weN;
    reP <= pinIn.reN;
    if (busy != 8'h0) busy <= busy - 8'h1;
    if (!weP && pinIn.weN && !pinIn.ceN) begin
      if (pinIn.cle) begin
        cmd <= pinIn.ioOut;
        sMode <= pinIn.ioOut inside {8'h70, 8'h78};
        if (pinIn.ioOut == 8'hff) busy <= 8'd30;
      end else if (pinIn.ale) begin
        cnt <= 3'h0;
        if (cmd == 8'h78) row <= {pinIn.ioOut, row[23:8]};
        if (cmd == 8'hef) fa <= pinIn.ioOut;
        if (cmd == 8'hec) busy <= 8'd20;
        if (cmd == 8'hec) ptr <= 10'h0;
      end else if (cmd == 8'hef) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h0 && fa == 8'h10) drive <= pinIn.ioOut;
        if (cnt != 3'h0) rsvOr <= rsvOr | pinIn.ioOut;
        if (cnt == 3'h3) busy <= 8'd10;
      end
    end
    if (!reP && pinIn.reN && !sMode) ptr <= ptr + 10'h1;
  end
endmodule
`default_nettype wire

// ===== nand_host_ctrl_tb_top.sv
// self-checking bench for the host nand controller
`timescale 1ns/10ps
`default_nettype none
module nand_host_ctrl_tb_top
  import nand_host_pkg::*;
;
  logic core_clk, rst_n, regWr, regRd, rbN;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, s;
  logic [7:0] ioIn, drive, rsvOr;
  logic [23:0] row;
  logic [15:0] crcVal;
  pins_s pinOut;
  int n_errors, comparisons;
  nand_host_ctrl #(.WIDE_PART(1'b0)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pinOut(pinOut), .ioIn(ioIn), .rbN(rbN));
  nand_dev_model dev_u (.core_clk(core_clk), .pinIn(pinOut), .ioIn(ioIn), .rbN(rbN),
    .drive(drive), .rsvOr(rsvOr), .row(row), .crcVal(crcVal));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // polls the busy bit; a hang is cut after a fixed bound
  task automatic wait_idle();
    s = 32'h1;
    for (int k = 0; s[0] !== 1'b0; k++) begin
      rd(12'h00c, s);
      if (k > 5000) begin
        chk(s, 32'h0);
        finish_test();
      end
    end
  endtask
  task automatic t_status();
    wr(12'h000, 32'h201);
    wait_idle();
    chk(s[15:8], 8'he0);
    chk(s[20:16], 5'b01100);
    chk(s[6], 1'b1);
    wr(12'h000, 32'h001);
    wait_idle();
    chk(s[15:8], 8'h60);
    chk(s[20], 1'b1);
    $display("test status done");
  endtask
  task automatic t_param();
    wr(12'h000, 32'h204);
    wait_idle();
    chk(s[4:2], 3'h7);
    rd(12'h010, s);
    chk(s, {crcVal, crcVal});
    for (int i = 0; i < 256; i++) begin
      rd(12'h400 + 12'(i * 4), s);
      chk(s[7:0], dev_u.pg[i]);
    end
    $display("test parameter page done");
  endtask
  task automatic t_feat();
    for (int d = 0; d < 4; d++) begin
      wr(12'h008, 32'((d + 2) % 4));
      wr(12'h000, 32'h203);
      wait_idle();
      chk(drive, 32'((d + 2) % 4));
    end
    chk(rsvOr, 8'h0);
    $display("test set feature done");
  endtask
  task automatic t_reset();
    // feature write is complete before reset is ordered
    wr(12'h000, 32'h205);
    wait_idle();
    chk(s[5], 1'b1);
    chk(s[15:8], 8'he0);
    chk(drive, 8'h01);
    rd(12'h008, s);
    chk(s, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_estat();
    wr(12'h004, 32'h123456);
    wr(12'h000, 32'h202);
    wait_idle();
    chk(row, 24'h123456);
    chk(s[15:8], 8'he0);
    wr(12'h000, 32'h302);
    rd(12'h00c, s);
    chk(s[1:0], 2'b10);
    wr(12'h000, 32'h204);
    wr(12'h000, 32'h201);
    rd(12'h00c, s);
    chk(s[1:0], 2'b11);
    wait_idle();
    $display("test enhanced status done");
  endtask
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'h0;
    regWdata = 32'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(regRdata, 32'h0);
    t_status();
    t_param();
    t_feat();
    t_reset();
    t_estat();
    finish_test();
  end
endmodule
`default_nettype wire
